// *** design/acms_pkg.sv ***
// constants for the axis control-mode switcher: register map, fields,
// mode codes, error codes.
// assumes a 32-bit APB master and one axis per instance.
package acms_pkg;

  // ****************************************
  // register map (byte addresses)
  // ****************************************
  localparam logic [7:0] ADDR_CTRL    = 8'h00;
  localparam logic [7:0] ADDR_MODESET = 8'h04;
  localparam logic [7:0] ADDR_TRQCMD  = 8'h08;
  localparam logic [7:0] ADDR_STAT1   = 8'h0C;
  localparam logic [7:0] ADDR_ERR     = 8'h10;
  localparam logic [7:0] ADDR_CMD     = 8'h14;

  // ****************************************
  // fields
  // ****************************************
  localparam int CTRL_REQ      = 0;
  localparam int CTRL_ZS_OFF   = 1;
  localparam int CTRL_SPD_LO   = 2;
  localparam int CTRL_SPD_HI   = 3;
  localparam int CTRL_TRQ_SEL  = 4;
  localparam int CTRL_POL_INV  = 5;
  localparam int CTRL_W        = 6;
  localparam int ERR_FLAG      = 16;
  localparam int ST2_ZERO_SPD  = 3;
  localparam int ST1_MODE_LO   = 2;
  localparam int ST1_MODE_HI   = 3;

  localparam logic [CTRL_W-1:0] CTRL_RESET = 6'h00;

  // ****************************************
  // codes
  // ****************************************
  localparam logic [7:0]  CODE_POS = 8'h00;
  localparam logic [7:0]  CODE_SPD = 8'h0A;
  localparam logic [7:0]  CODE_TRQ = 8'h14;
  localparam logic [1:0]  ST_POS   = 2'h0;
  localparam logic [1:0]  ST_SPD   = 2'h1;
  localparam logic [1:0]  ST_TRQ   = 2'h2;
  localparam logic [1:0]  SPD_CMD0 = 2'h0;
  localparam logic [1:0]  SPD_FB   = 2'h1;
  localparam logic [15:0] ERR_BUSY = 16'h0065;
  localparam logic [15:0] ERR_MOVE = 16'h009C;
  localparam logic [15:0] ERR_POL  = 16'h009A;

  typedef enum logic [2:0] {
    ACMS_POS = 3'b001,
    ACMS_SPD = 3'b010,
    ACMS_TRQ = 3'b100
  } acms_mode_t;

endpackage : acms_pkg

// *** design/acms_top.sv ***
// axis control-mode switcher: position / speed / torque control modes.
// assumes synchronous inputs from the servo link and positioning engine,
// and an APB master on the same clock.
`timescale 1ns/10ps
`default_nettype none

module acms_top #(
  parameter int W = 32
) (
  input  wire logic          clk_sys,
  input  wire logic          rst,
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [7:0]    paddr,
  input  wire logic [31:0]   pwdata,
  output logic      [31:0]   prdata,
  output logic               pready,
  output logic               pslverr,
  input  wire logic [15:0]   servo_status1_in,
  input  wire logic [15:0]   axis_servo_status_word2,
  input  wire logic          positioning_busy,
  input  wire logic          pos_start_done_in,
  input  wire logic          pos_done_in,
  input  wire logic          speed_active_in,
  input  wire logic          press_req_in,
  input  wire logic [W-1:0]  motor_speed_fb,
  input  wire logic [W-1:0]  motor_current_fb,
  input  wire logic [W-1:0]  feed_value,
  output logic               axis_start_accepted,
  output logic               positioning_start_done,
  output logic               positioning_done,
  output logic               speed_ctrl_active_flag,
  output logic               press_enable,
  output logic [15:0]        axis_servo_status_word1,
  output logic [W-1:0]       speed_cmd,
  output logic [W-1:0]       torque_cmd,
  output logic [W-1:0]       pos_cmd,
  output logic               cmd_load
);

  // ****************************************
  // bus slave
  // ****************************************
  logic [acms_pkg::CTRL_W-1:0] ctrl;
  logic [7:0]                  mode_set;
  logic [W-1:0]                trq_cmd_word;
  logic [15:0]                 err_code;
  logic                        err_flag;
  acms_pkg::acms_mode_t        mode;
  logic                        req_q;
  logic                        wr_en;
  logic                        mapped;
  logic [31:0]                 next_rdata;
  logic [1:0]                  mode_bits;

  // ready is answered in the first access cycle, so every transfer
  // costs exactly two cycles
  assign wr_en = psel & penable & pwrite & pready;

  always_comb begin
    mapped = 1'b1;
    next_rdata = 32'h0000_0000;
    case (paddr)
      acms_pkg::ADDR_CTRL:    next_rdata[acms_pkg::CTRL_W-1:0] = ctrl;
      acms_pkg::ADDR_MODESET: next_rdata[7:0] = mode_set;
      acms_pkg::ADDR_TRQCMD:  next_rdata = 32'(trq_cmd_word);
      acms_pkg::ADDR_STAT1:   next_rdata[15:0] = axis_servo_status_word1;
      acms_pkg::ADDR_ERR:     next_rdata = {15'h0000, err_flag, err_code};
      acms_pkg::ADDR_CMD:     next_rdata[1:0] = mode_bits;
      default:                mapped = 1'b0;
    endcase
  end

  // prdata is forced to zero outside the answer cycle, so a stale read
  // value never lingers on the bus
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~mapped;
      prdata  <= (psel & ~penable & ~pwrite) ? next_rdata : 32'h0000_0000;
    end
  end

  // read-only and unmapped offsets match no decoder below, so a stray
  // write there leaves all state alone
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ctrl <= acms_pkg::CTRL_RESET;
    end else if (wr_en & (paddr == acms_pkg::ADDR_CTRL)) begin
      ctrl <= pwdata[acms_pkg::CTRL_W-1:0];
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      mode_set <= acms_pkg::CODE_POS;
    end else if (wr_en & (paddr == acms_pkg::ADDR_MODESET)) begin
      mode_set <= pwdata[7:0];
    end
  end

  // the torque word is a plain store; it only reaches torque_cmd at a switch into torque
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      trq_cmd_word <= '0;
    end else if (wr_en & (paddr == acms_pkg::ADDR_TRQCMD)) begin
      trq_cmd_word <= pwdata[W-1:0];
    end
  end

  // ****************************************
  // request evaluation
  // ****************************************
  logic       req_edge;
  logic       stopped;
  logic       busy_ok;
  logic       stop_ok;
  logic       want_pos;
  logic       want_spd;
  logic       want_trq;
  logic       go;
  logic       fail;
  logic       pol_err;
  logic [15:0] fail_code;
  logic       err_clr;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      req_q <= 1'b0;
    end else begin
      req_q <= ctrl[acms_pkg::CTRL_REQ];
    end
  end

  assign req_edge = ctrl[acms_pkg::CTRL_REQ] & ~req_q;
  assign stopped  = axis_servo_status_word2[acms_pkg::ST2_ZERO_SPD]
                  | ctrl[acms_pkg::CTRL_ZS_OFF];
  // the bypass option only lifts the stop check; the busy check stays
  assign busy_ok  = ~axis_start_accepted;
  assign want_pos = mode_set == acms_pkg::CODE_POS;
  assign want_spd = mode_set == acms_pkg::CODE_SPD;
  assign want_trq = mode_set == acms_pkg::CODE_TRQ;

  // a code naming the current mode, or no mode at all, is dropped
  // without an error: such a request has nothing to do
  always_comb begin
    go        = 1'b0;
    fail      = 1'b0;
    fail_code = acms_pkg::ERR_MOVE;
    stop_ok   = stopped;
    if (req_edge) begin
      case (mode)
        acms_pkg::ACMS_POS: begin
          if (want_spd | want_trq) begin
            if (!busy_ok) begin
              fail      = 1'b1;
              fail_code = acms_pkg::ERR_BUSY;
            end else if (!stop_ok) begin
              fail = 1'b1;
            end else begin
              go = 1'b1;
            end
          end
        end
        acms_pkg::ACMS_SPD: begin
          if (want_pos) begin
            go   = stop_ok;
            fail = ~stop_ok;
          end else if (want_trq) begin
            go = 1'b1;
          end
        end
        acms_pkg::ACMS_TRQ: begin
          if (want_pos) begin
            go   = stop_ok;
            fail = ~stop_ok;
          end else if (want_spd) begin
            go = 1'b1;
          end
        end
        default: ;
      endcase
    end
  end

  // feedback torque is refused while polarity reflection is invalid (CTRL_POL_INV low)
  assign pol_err = go & want_trq & ctrl[acms_pkg::CTRL_TRQ_SEL]
                 & ~ctrl[acms_pkg::CTRL_POL_INV];

  // ****************************************
  // mode register
  // ****************************************
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      mode <= acms_pkg::ACMS_POS;
    end else if (go) begin
      case (1'b1)
        want_spd: mode <= acms_pkg::ACMS_SPD;
        want_trq: mode <= acms_pkg::ACMS_TRQ;
        default:  mode <= acms_pkg::ACMS_POS;
      endcase
    end
  end

  always_comb begin
    case (mode)
      acms_pkg::ACMS_SPD: mode_bits = acms_pkg::ST_SPD;
      acms_pkg::ACMS_TRQ: mode_bits = acms_pkg::ST_TRQ;
      default:            mode_bits = acms_pkg::ST_POS;
    endcase
  end

  // ****************************************
  // minor error report
  // ****************************************
  // write 1 to the flag bit clears it; a new error in that cycle wins
  assign err_clr = wr_en & (paddr == acms_pkg::ADDR_ERR)
                 & pwdata[acms_pkg::ERR_FLAG];

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      err_flag <= 1'b0;
      err_code <= 16'h0000;
    end else if (fail) begin
      err_flag <= 1'b1;
      err_code <= fail_code;
    end else if (pol_err) begin
      err_flag <= 1'b1;
      err_code <= acms_pkg::ERR_POL;
    end else if (err_clr) begin
      err_flag <= 1'b0;
    end
  end

  // ****************************************
  // first commands after a switch
  // ****************************************
  // cmd_load marks the first cycle in which the new command stands
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cmd_load <= 1'b0;
    end else begin
      cmd_load <= go;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pos_cmd <= '0;
    end else if (go & want_pos) begin
      pos_cmd <= feed_value;
    end
  end

  // leaving torque, the measured speed wins over the option so the
  // motor sees no step when torque control lets go
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      speed_cmd <= '0;
    end else if (go & want_spd) begin
      if (mode == acms_pkg::ACMS_TRQ) begin
        speed_cmd <= motor_speed_fb;
      end else if (ctrl[acms_pkg::CTRL_SPD_HI:acms_pkg::CTRL_SPD_LO]
                   == acms_pkg::SPD_FB) begin
        speed_cmd <= motor_speed_fb;
      end else begin
        speed_cmd <= '0;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      torque_cmd <= '0;
    end else if (go & want_trq) begin
      if (ctrl[acms_pkg::CTRL_TRQ_SEL] & ~pol_err) begin
        torque_cmd <= motor_current_fb;
      end else begin
        torque_cmd <= trq_cmd_word;
      end
    end
  end

  // ****************************************
  // axis flags
  // ****************************************
  // the registered mode decides, so the flag moves in the same cycle as
  // the mode field of the status word and the two never disagree
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      axis_start_accepted <= 1'b0;
    end else begin
      axis_start_accepted <= positioning_busy
                           | (mode != acms_pkg::ACMS_POS);
    end
  end

  // a mode switch alone never raises these
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      positioning_start_done <= 1'b0;
      positioning_done       <= 1'b0;
    end else begin
      positioning_start_done <= pos_start_done_in & ~go
                              & (mode == acms_pkg::ACMS_POS);
      positioning_done       <= pos_done_in & ~go
                              & (mode == acms_pkg::ACMS_POS);
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      speed_ctrl_active_flag <= 1'b0;
      press_enable           <= 1'b0;
    end else begin
      speed_ctrl_active_flag <= speed_active_in
                              & (mode != acms_pkg::ACMS_SPD);
      press_enable           <= press_req_in
                              & (mode != acms_pkg::ACMS_SPD);
    end
  end

  // the raw word passes through; only the mode field is ours
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      axis_servo_status_word1 <= 16'h0000;
    end else begin
      axis_servo_status_word1 <= servo_status1_in;
      axis_servo_status_word1[acms_pkg::ST1_MODE_HI:acms_pkg::ST1_MODE_LO]
                              <= mode_bits;
    end
  end

endmodule : acms_top

`default_nettype wire

// *** tb/acms_checker.sv ***
// checker for the mode switcher, watching the top module's ports only.
// assumes one clock domain and the bind at the foot of this file.
`timescale 1ns/10ps
`default_nettype none
module acms_checker #(
  parameter int W = 32
) (
  input wire logic         clk_sys,
  input wire logic         rst,
  input wire logic [15:0]  servo_status1_in,
  input wire logic [W-1:0] motor_speed_fb,
  input wire logic [W-1:0] feed_value,
  input wire logic         axis_start_accepted,
  input wire logic         positioning_start_done,
  input wire logic         positioning_done,
  input wire logic         speed_ctrl_active_flag,
  input wire logic         press_enable,
  input wire logic [15:0]  axis_servo_status_word1,
  input wire logic [W-1:0] speed_cmd,
  input wire logic [W-1:0] torque_cmd,
  input wire logic [W-1:0] pos_cmd,
  input wire logic         cmd_load
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  logic [1:0] md;
  assign md = axis_servo_status_word1[3:2];
  a_mode_legal: assert property (md != 2'h3)
    else $error("mode field holds 11");
  a_status_copy: assert property (!$past(rst) |->
    ((axis_servo_status_word1 ^ $past(servo_status1_in)) & 16'hFFF3) == 16'h0000)
    else $error("status word bits lost");
  a_run_accept: assert property (md != acms_pkg::ST_POS |-> axis_start_accepted)
    else $error("start flag low while running");
  a_spd_masks: assert property (md == acms_pkg::ST_SPD |->
    !speed_ctrl_active_flag && !press_enable) else $error("speed mode mask broken");
  a_done_masks: assert property (md != acms_pkg::ST_POS |->
    !positioning_start_done && !positioning_done) else $error("done flag outside position");
  a_cmd_hold: assert property (!cmd_load |->
    $stable(speed_cmd) && $stable(torque_cmd) && $stable(pos_cmd))
    else $error("command moved without switch");
  a_pos_load: assert property (cmd_load |-> ##1
    (md != acms_pkg::ST_POS || pos_cmd == $past(feed_value, 2)))
    else $error("position command not feed value");
  a_trq_to_spd: assert property (cmd_load && md == acms_pkg::ST_TRQ |-> ##1
    (md != acms_pkg::ST_SPD || speed_cmd == $past(motor_speed_fb, 2)))
    else $error("speed command not measured speed");
  a_exit_idle: assert property (cmd_load && md == acms_pkg::ST_POS |->
    !$past(axis_start_accepted)) else $error("left position while busy");
endmodule : acms_checker
bind acms_top acms_checker #(.W(W)) u_chk (.clk_sys, .rst, .servo_status1_in,
  .motor_speed_fb, .feed_value, .axis_start_accepted, .positioning_start_done,
  .positioning_done, .speed_ctrl_active_flag, .press_enable, .axis_servo_status_word1,
  .speed_cmd, .torque_cmd, .pos_cmd, .cmd_load);
`default_nettype wire

// *** tb/acms_servo_model.sv ***
// behavioural servo amplifier: status words and feedback values.
// assumes the bench says whether the motor turns.
`timescale 1ns/10ps
`default_nettype none
module acms_servo_model (
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic        moving,
  output logic      [15:0] status1,
  output logic      [15:0] status2,
  output logic      [31:0] speed_fb,
  output logic      [31:0] current_fb,
  output logic      [31:0] feed
);
  // status1 changes every cycle so a stale copy shows up
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      status1 <= 16'h0000;
      status2 <= 16'h0000;
      speed_fb <= 32'h0;
      current_fb <= 32'h0;
      feed <= 32'h0;
    end else begin
      status1 <= status1 + 16'h1235;
      status2 <= {12'h000, ~moving, 3'h0};
      speed_fb <= moving ? 32'h321 : 32'h0;
      current_fb <= 32'h456;
      feed <= feed + (moving ? 32'h321 : 32'h0);
    end
  end
endmodule : acms_servo_model
`default_nettype wire

// *** tb/tb_axis_control_mode_switcher.sv ***
// bench for the mode switcher: APB master tasks, one task per scenario.
// assumes acms_top, the servo model and the bound checker.
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin n_mismatch++; \
  $display("unexpected %s exp %h got %h", nm, e, g); end end
module tb_axis_control_mode_switcher;
  logic        clk_sys = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
  logic        moving = 0, busy = 0, flg = 1, pready, pslverr, acc, err, pdone;
  logic [7:0]  paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd, sfb, cfb, feed, speed_cmd, torque_cmd, pos_cmd;
  logic [15:0] st1, st2, word1;
  logic [15:0] last_ec = 16'h0000;
  int          n_mismatch = 0, tests_run = 0;
  acms_servo_model srv (.clk_sys, .rst, .moving, .status1(st1), .status2(st2),
    .speed_fb(sfb), .current_fb(cfb), .feed);
  acms_top DUT (.clk_sys, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .servo_status1_in(st1), .axis_servo_status_word2(st2),
    .positioning_busy(busy), .pos_start_done_in(flg), .pos_done_in(flg),
    .speed_active_in(flg), .press_req_in(flg), .motor_speed_fb(sfb),
    .motor_current_fb(cfb), .feed_value(feed), .axis_start_accepted(acc),
    .positioning_start_done(), .positioning_done(pdone), .speed_ctrl_active_flag(),
    .press_enable(), .axis_servo_status_word1(word1), .speed_cmd, .torque_cmd,
    .pos_cmd, .cmd_load());
  initial forever #2.5 clk_sys = ~clk_sys;
  // ****************************************
  // bus tasks
  // ****************************************
  task automatic finish_test;
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : finish_test
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
    if (pready !== 1'b1) begin
      n_mismatch++;
      finish_test();
    end
  endtask : apb
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    apb(0, a, 32'h0);
    `CHK("read", e, rd)
  endtask : rchk
  // request edge: options with the bit low, then high; error cleared after
  task automatic sw(input logic [7:0] c, input logic [5:0] o, input logic [1:0] m,
                    input logic [15:0] ec);
    apb(1, acms_pkg::ADDR_MODESET, {24'h0, c});
    apb(1, acms_pkg::ADDR_CTRL, {26'h0, o});
    apb(1, acms_pkg::ADDR_CTRL, {26'h0, o | 6'h01});
    repeat (3) @(posedge clk_sys);
    `CHK("mode", m, word1[3:2])
    if (ec != 16'h0000) begin
      last_ec = ec;
    end
    // the code field keeps the last error after its flag is cleared
    rchk(acms_pkg::ADDR_ERR, {15'h0000, ec != 16'h0000, last_ec});
    apb(1, acms_pkg::ADDR_ERR, 32'h0001_0000);
  endtask : sw
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_regs;
    rchk(acms_pkg::ADDR_CTRL, 32'h0);
    rchk(acms_pkg::ADDR_ERR, 32'h0);
    apb(1, 8'h40, 32'h1);
    `CHK("pslverr", 1'b1, err)
    $display("regs done");
  endtask : t_regs
  task automatic t_pos_exit;
    busy <= 1;
    sw(acms_pkg::CODE_SPD, 6'h00, acms_pkg::ST_POS, acms_pkg::ERR_BUSY);
    busy <= 0;
    moving <= 1;
    sw(acms_pkg::CODE_SPD, 6'h00, acms_pkg::ST_POS, acms_pkg::ERR_MOVE);
    sw(acms_pkg::CODE_SPD, 6'h06, acms_pkg::ST_SPD, 16'h0);
    `CHK("speed_cmd", 32'h321, speed_cmd)
    `CHK("accepted", 1'b1, acc)
    $display("position exit done");
  endtask : t_pos_exit
  task automatic t_spd_trq;
    apb(1, acms_pkg::ADDR_TRQCMD, 32'h777);
    sw(acms_pkg::CODE_TRQ, 6'h10, acms_pkg::ST_TRQ, acms_pkg::ERR_POL);
    `CHK("torque_cmd", 32'h777, torque_cmd)
    sw(acms_pkg::CODE_SPD, 6'h00, acms_pkg::ST_SPD, 16'h0);
    `CHK("speed_cmd", 32'h321, speed_cmd)
    moving <= 0;
    sw(acms_pkg::CODE_TRQ, 6'h30, acms_pkg::ST_TRQ, 16'h0);
    `CHK("torque_cmd", 32'h456, torque_cmd)
    $display("speed torque done");
  endtask : t_spd_trq
  task automatic t_to_pos;
    moving <= 1;
    sw(acms_pkg::CODE_POS, 6'h00, acms_pkg::ST_TRQ, acms_pkg::ERR_MOVE);
    moving <= 0;
    sw(acms_pkg::CODE_POS, 6'h00, acms_pkg::ST_POS, 16'h0);
    `CHK("pos_cmd", feed, pos_cmd)
    `CHK("accepted", 1'b0, acc)
    `CHK("done flag", 1'b1, pdone)
    $display("return to position done");
  endtask : t_to_pos
  task automatic t_hold;
    moving <= 1;
    sw(acms_pkg::CODE_SPD, 6'h0A, acms_pkg::ST_SPD, 16'h0);
    `CHK("speed_cmd", 32'h0, speed_cmd)
    apb(1, acms_pkg::ADDR_MODESET, 32'h14);
    apb(1, acms_pkg::ADDR_CTRL, 32'h01);
    repeat (3) @(posedge clk_sys);
    `CHK("held request", acms_pkg::ST_SPD, word1[3:2])
    $display("held request done");
  endtask : t_hold
  initial begin
    repeat (12) @(posedge clk_sys);
    rst <= 0;
    t_regs();
    t_pos_exit();
    t_spd_trq();
    t_to_pos();
    t_hold();
    rst <= 1;
    repeat (2) @(posedge clk_sys);
    rst <= 0;
    repeat (2) @(posedge clk_sys);
    `CHK("reset mode", acms_pkg::ST_POS, word1[3:2])
    finish_test();
  end
endmodule : tb_axis_control_mode_switcher
`default_nettype wire
